// ==== shared/xpi_regs.svh ====
// Purpose: Register map, field positions, reset values and timing for the external pin
//          interrupt block.
// Assumes: 8-bit register port, 125 MHz system clock.
// Notes:   Definitions only.
`ifndef XPI_REGS_SVH
`define XPI_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define XPI_OFS_SENSE      8'h00
`define XPI_OFS_CSTAT      8'h01
`define XPI_OFS_ENABLE     8'h02
`define XPI_OFS_FLAG       8'h03
`define XPI_OFS_STATE      8'h04

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define XPI_SENSE_L0_LSB   0
`define XPI_SENSE_L1_LSB   2
`define XPI_EDGE_SEL_BIT   6
`define XPI_BIT_LINE_ONE   7
`define XPI_BIT_LINE_ZERO  6
`define XPI_BIT_LINE_ASYNC 5
`define XPI_ST_IO_RUN      7
`define XPI_ST_STARTING    6
`define XPI_ST_WAKE        5
`define XPI_ST_PINS_LSB    0
`define XPI_RST_BYTE       8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define XPI_CLK_PERIOD_PS  8000
`define XPI_STARTUP_NS     65000

`endif

// ==== shared/xpi_pkg.sv ====
// Purpose: Types shared by the external pin interrupt block.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Sense codes follow the two-bit field order.
package xpi_pkg;

  typedef enum logic [1:0] {
    XPI_SENSE_LOW,
    XPI_SENSE_ANY,
    XPI_SENSE_FALL,
    XPI_SENSE_RISE
  } xpi_sense_e;

  typedef enum logic [2:0] {
    XPI_SLP_IDLE,
    XPI_SLP_ADC,
    XPI_SLP_PDOWN,
    XPI_SLP_PSAVE,
    XPI_SLP_STBY,
    XPI_SLP_XSTBY
  } xpi_sleep_e;

  typedef enum logic [1:0] {
    XPI_WK_IDLE,
    XPI_WK_FIRST,
    XPI_WK_START
  } xpi_wake_e;

endpackage

// ==== shared/xpi_det_if.sv ====
// Purpose: Carries one line's pin, sense and run enable to its detector and the results back.
// Assumes: Single clock domain.
// Notes:   One instance per line.
`timescale 1ns/1ps
interface xpi_det_if;
  import xpi_pkg::*;
  logic       pin;
  xpi_sense_e sense;
  logic       run;
  logic       evt;
  logic       low;
  modport det (input pin, input sense, input run, output evt, output low);
  modport ctl (output pin, output sense, output run, input evt, input low);
endinterface

// ==== src/xpi_line_det.sv ====
// Purpose: Edge and low-level detection for one interrupt line.
// Assumes: Pin already passed through a two-stage synchroniser.
// Notes:   With ASYNC_ONLY set, sense bit 0 is the edge select and level is never reported.
`timescale 1ns/1ps
module xpi_line_det #(
  parameter bit ASYNC_ONLY = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  xpi_det_if.det   d
);
  import xpi_pkg::*;

  logic prev_r;
  logic armed_r;
  logic rise;
  logic fall;

  // Previous sample only tracks while the detector clock runs; on restart the
  // first sample re-arms without reporting, so a stopped clock makes no edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_r  <= 1'b1;
      armed_r <= 1'b0;
    end else if (d.run) begin
      prev_r  <= d.pin;
      armed_r <= 1'b1;
    end else begin
      armed_r <= 1'b0;
    end
  end

  assign rise = d.run && armed_r && d.pin && !prev_r;
  assign fall = d.run && armed_r && !d.pin && prev_r;

  always_comb begin
    if (ASYNC_ONLY) begin
      d.evt = d.sense[0] ? rise : fall;
    end else begin
      unique case (d.sense)
        XPI_SENSE_LOW:  d.evt = 1'b0;
        XPI_SENSE_ANY:  d.evt = rise | fall;
        XPI_SENSE_FALL: d.evt = fall;
        XPI_SENSE_RISE: d.evt = rise;
      endcase
    end
  end

  // Level view needs no running detector clock
  assign d.low = !ASYNC_ONLY && (d.sense == XPI_SENSE_LOW) && !d.pin;
endmodule

// ==== src/xpi_wake_qual.sv ====
// Purpose: Qualifies a level wake from deep sleep on two watchdog-clock samples, then times
//          the start-up window.
// Assumes: wdt_tick is a one-cycle pulse per watchdog oscillator period.
// Notes:   Start-up length is a parameter so simulation can shorten it.
`timescale 1ns/1ps
module xpi_wake_qual #(
  parameter int STARTUP_CYCLES = 8125
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic deep_sleep,
  input  wire logic wdt_tick,
  input  wire logic level_low,
  output logic      wake,
  output logic      starting
);
  import xpi_pkg::*;

  xpi_wake_e   state_r;
  logic [31:0] cnt_r;

  assign starting = (state_r == XPI_WK_START);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= XPI_WK_IDLE;
      cnt_r   <= 32'h0;
      wake    <= 1'b0;
    end else begin
      wake <= 1'b0;
      unique case (state_r)
        XPI_WK_IDLE: begin
          if (deep_sleep && wdt_tick && level_low) begin
            state_r <= XPI_WK_FIRST;
          end
        end
        XPI_WK_FIRST: begin
          if (!deep_sleep || (wdt_tick && !level_low)) begin
            state_r <= XPI_WK_IDLE;
          end else if (wdt_tick) begin
            state_r <= XPI_WK_START;
            wake    <= 1'b1;
            cnt_r   <= 32'h0;
          end
        end
        XPI_WK_START: begin
          if (cnt_r == 32'(STARTUP_CYCLES - 1)) begin
            state_r <= XPI_WK_IDLE;
          end else begin
            cnt_r <= cnt_r + 32'h1;
          end
        end
      endcase
    end
  end
endmodule

// ==== src/xpi_top.sv ====
// Purpose: External pin interrupt controller: three pin lines, sense and enable registers,
//          pending flags, requests to the core and wake from sleep.
// Assumes: Pins are asynchronous to clk_sys; register port and core signals are synchronous.
// Notes:   The async line is modelled as always-sampled logic that ignores the I/O clock gate.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "xpi_regs.svh"
module xpi_top #(
  parameter int STARTUP_CYCLES =
    (`XPI_STARTUP_NS * 1000 + `XPI_CLK_PERIOD_PS - 1) / `XPI_CLK_PERIOD_PS
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  input  wire logic          ext_irq_line_zero,
  input  wire logic          ext_irq_line_one,
  input  wire logic          ext_irq_line_async,
  input  wire logic          wdt_osc_clk,
  input  wire logic          global_irq_en,
  input  wire logic [2:0]    irq_ack,
  input  wire logic          sleep_en,
  input  wire xpi_pkg::xpi_sleep_e sleep_mode,
  output logic      [2:0]    irq_req,
  output logic               irq,
  output logic               io_clk_run,
  output logic               wake_req
);
  import xpi_pkg::*;

  // ----------------------------------------------------------------------
  // Line index helpers
  // ----------------------------------------------------------------------
  localparam int LZ = 0;
  localparam int LO = 1;
  localparam int LA = 2;

  // Gathers per-line bits into the shared byte layout
  function automatic logic [7:0] pack_lines(input logic [2:0] v);
    logic [7:0] b;
    b = `XPI_RST_BYTE;
    b[`XPI_BIT_LINE_ZERO]  = v[LZ];
    b[`XPI_BIT_LINE_ONE]   = v[LO];
    b[`XPI_BIT_LINE_ASYNC] = v[LA];
    return b;
  endfunction

  function automatic logic [2:0] unpack_lines(input logic [7:0] b);
    logic [2:0] v;
    v     = 3'h0;
    v[LZ] = b[`XPI_BIT_LINE_ZERO];
    v[LO] = b[`XPI_BIT_LINE_ONE];
    v[LA] = b[`XPI_BIT_LINE_ASYNC];
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic       wdt_s1_r;
  logic       wdt_s2_r;
  logic       wdt_s3_r;
  logic       wdt_tick;

  // The pad level is read whatever the pin's direction, so a line driven by
  // the device's own port output still raises its interrupt
  assign pin_raw = {ext_irq_line_async, ext_irq_line_one, ext_irq_line_zero};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1_r <= 3'h7;
      pin_s2_r <= 3'h7;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Oscillator is far slower than clk_sys; a third stage turns its rising edge into a tick
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wdt_s1_r <= 1'b0;
      wdt_s2_r <= 1'b0;
      wdt_s3_r <= 1'b0;
    end else begin
      wdt_s1_r <= wdt_osc_clk;
      wdt_s2_r <= wdt_s1_r;
      wdt_s3_r <= wdt_s2_r;
    end
  end

  // One sample per watchdog oscillator period, taken on its rising edge
  assign wdt_tick = wdt_s2_r && !wdt_s3_r;

  // ----------------------------------------------------------------------
  // Sleep and I/O clock gate
  // ----------------------------------------------------------------------
  logic deep_sleep;

  always_comb begin
    if (!sleep_en) begin
      io_clk_run = 1'b1;
    end else begin
      unique case (sleep_mode)
        XPI_SLP_IDLE: io_clk_run = 1'b1;
        XPI_SLP_ADC,
        XPI_SLP_PDOWN,
        XPI_SLP_PSAVE,
        XPI_SLP_STBY,
        XPI_SLP_XSTBY: io_clk_run = 1'b0;
        default:       io_clk_run = 1'b0;
      endcase
    end
  end

  assign deep_sleep = sleep_en && !io_clk_run;

  // ----------------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------------
  logic       wr_sense;
  logic       wr_cstat;
  logic       wr_en;
  logic       wr_flag;

  // Writes to unmapped offsets miss every decode and change nothing
  assign wr_sense = reg_wr && (reg_addr == `XPI_OFS_SENSE);
  assign wr_cstat = reg_wr && (reg_addr == `XPI_OFS_CSTAT);
  assign wr_en    = reg_wr && (reg_addr == `XPI_OFS_ENABLE);
  assign wr_flag  = reg_wr && (reg_addr == `XPI_OFS_FLAG);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [7:0] sense_r;
  logic [7:0] cstat_r;
  logic [2:0] en_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sense_r <= `XPI_RST_BYTE;
      cstat_r <= `XPI_RST_BYTE;
    end else begin
      if (wr_sense) begin
        sense_r <= reg_wdata;
      end
      if (wr_cstat) begin
        cstat_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_r <= 3'h0;
    end else if (wr_en) begin
      en_r <= unpack_lines(reg_wdata);
    end
  end

  // ----------------------------------------------------------------------
  // Line detectors
  // ----------------------------------------------------------------------
  xpi_det_if det_if [3] ();
  logic [2:0] evt;
  logic [2:0] low;
  logic [2:0] level_mode;

  assign det_if[LZ].pin   = pin_s2_r[LZ];
  assign det_if[LZ].sense = xpi_sense_e'(sense_r[`XPI_SENSE_L0_LSB +: 2]);
  assign det_if[LZ].run   = io_clk_run;
  assign det_if[LO].pin   = pin_s2_r[LO];
  assign det_if[LO].sense = xpi_sense_e'(sense_r[`XPI_SENSE_L1_LSB +: 2]);
  assign det_if[LO].run   = io_clk_run;
  assign det_if[LA].pin   = pin_s2_r[LA];
  // Async line: edge select rides in the low sense bit, level code never used
  assign det_if[LA].sense = cstat_r[`XPI_EDGE_SEL_BIT] ? XPI_SENSE_RISE : XPI_SENSE_FALL;
  assign det_if[LA].run   = 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_det
      xpi_line_det #(
        .ASYNC_ONLY (gi == LA)
      ) u_det (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (det_if[gi])
      );
      assign evt[gi]        = det_if[gi].evt;
      assign low[gi]        = det_if[gi].low;
      assign level_mode[gi] = (gi != LA) && (det_if[gi].sense == XPI_SENSE_LOW);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------------
  logic [2:0] flag_r;
  logic [2:0] flag_clr;

  // Hardware clear in level mode; a new edge in the clear cycle still sets
  assign flag_clr = irq_ack | (wr_flag ? unpack_lines(reg_wdata) : 3'h0) | level_mode;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_r <= 3'h0;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | evt;
    end
  end

  // ----------------------------------------------------------------------
  // Wake qualification
  // ----------------------------------------------------------------------
  logic level_wake_src;
  logic qual_wake;
  logic starting;

  assign level_wake_src = |(low & en_r);

  xpi_wake_qual #(
    .STARTUP_CYCLES (STARTUP_CYCLES)
  ) u_wake (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .deep_sleep (deep_sleep),
    .wdt_tick   (wdt_tick),
    .level_low  (level_wake_src),
    .wake       (qual_wake),
    .starting   (starting)
  );

  // ----------------------------------------------------------------------
  // Wake request
  // ----------------------------------------------------------------------
  // Wake request holds until the core leaves sleep; edge wakes need no
  // watchdog samples, so one caught edge on an enabled line is enough
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else if (!sleep_en) begin
      wake_req <= 1'b0;
    end else if (qual_wake) begin
      wake_req <= 1'b1;
    end else if (io_clk_run && level_wake_src) begin
      wake_req <= 1'b1;
    end else if (|(evt & en_r)) begin
      wake_req <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Requests to the core
  // ----------------------------------------------------------------------
  logic [2:0] level_act;

  // No level request while start-up runs or the core is in deep sleep; a source
  // that lets go early therefore wakes the device but is never serviced
  assign level_act = (starting || deep_sleep) ? 3'h0 : low;

  assign irq_req = {3{global_irq_en}} & en_r & (flag_r | level_act);

  // ----------------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------------
  // One level output; the core picks the line from irq_req and acknowledges it
  assign irq     = |irq_req;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [7:0] state_byte;

  always_comb begin
    state_byte = `XPI_RST_BYTE;
    state_byte[`XPI_ST_IO_RUN]   = io_clk_run;
    state_byte[`XPI_ST_STARTING] = starting;
    state_byte[`XPI_ST_WAKE]     = wake_req;
    state_byte[`XPI_ST_PINS_LSB +: 3] = pin_s2_r;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= `XPI_RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `XPI_OFS_SENSE:  reg_rdata <= sense_r;
        `XPI_OFS_CSTAT:  reg_rdata <= cstat_r;
        `XPI_OFS_ENABLE: reg_rdata <= pack_lines(en_r);
        `XPI_OFS_FLAG:   reg_rdata <= pack_lines(flag_r);
        `XPI_OFS_STATE:  reg_rdata <= state_byte;
        default:         reg_rdata <= `XPI_RST_BYTE;
      endcase
    end else begin
      reg_rdata <= `XPI_RST_BYTE;
    end
  end
endmodule

// ==== bench/xpi_pin_src.sv ====
// Purpose: Board side of the interrupt pins and the watchdog oscillator.
// Assumes: Pin levels come from the bench; oscillator period about 1 us.
// Notes:   No pull-ups; pins copy lvl, and the bench holds them high when idle.
`timescale 1ns/1ps
module xpi_pin_src #(
  parameter real WDT_HALF_NS = 500.0
) (
  input  wire logic [2:0] lvl,
  output logic      [2:0] pin,
  output logic            wdt_clk
);
  // Free-running, phase unrelated to clk_sys
  initial begin
    wdt_clk = 1'b0;
    #3.3;
    forever #(WDT_HALF_NS) wdt_clk = ~wdt_clk;
  end
  // Own output driver and board source look alike at the pad
  assign pin = lvl;
endmodule

// ==== bench/xpi_top_monitor.sv ====
// Purpose: Port-level assertions for the external pin interrupt block.
// Assumes: Register contents are mirrored from the register port.
// Notes:   Level checks wait out the start-up window after sleep.
`timescale 1ns/1ps
`include "xpi_regs.svh"
module xpi_top_monitor #(
  parameter int STARTUP_CYCLES = 8125
) (
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic                ext_irq_line_zero,
  input wire logic                ext_irq_line_async,
  input wire logic                global_irq_en,
  input wire logic [2:0]          irq_ack,
  input wire logic                sleep_en,
  input wire xpi_pkg::xpi_sleep_e sleep_mode,
  input wire logic [2:0]          irq_req,
  input wire logic                irq,
  input wire logic                io_clk_run,
  input wire logic                wake_req
);
  import xpi_pkg::*;
  localparam int          WDT_CYC = 125;
  localparam int unsigned QUIET   = STARTUP_CYCLES + 4;
  // ----------------------------------------------------------------------
  // Register mirror
  // ----------------------------------------------------------------------
  logic [7:0]  sense_r;
  logic [7:0]  cstat_r;
  logic [7:0]  en_r;
  int unsigned quiet_r;
  logic        deep, awake, lvl0_on, fall0_on, asy_on, lvl_only;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sense_r <= `XPI_RST_BYTE;
      cstat_r <= `XPI_RST_BYTE;
      en_r    <= `XPI_RST_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == `XPI_OFS_SENSE) sense_r <= reg_wdata;
      if (reg_addr == `XPI_OFS_CSTAT) cstat_r <= reg_wdata;
      if (reg_addr == `XPI_OFS_ENABLE) en_r <= reg_wdata;
    end
  end
  // Level checks are held off until start-up is surely over
  always_ff @(posedge clk_sys) begin
    if (rst || sleep_en) quiet_r <= 0;
    else if (quiet_r < QUIET) quiet_r <= quiet_r + 1;
  end
  assign deep     = sleep_en && (sleep_mode != XPI_SLP_IDLE);
  assign awake    = !sleep_en && (quiet_r >= QUIET);
  assign lvl0_on  = sense_r[1:0] == 2'b00 && en_r[`XPI_BIT_LINE_ZERO] && global_irq_en;
  assign fall0_on = sense_r[1:0] == 2'b10 && en_r[`XPI_BIT_LINE_ZERO] && global_irq_en;
  assign asy_on   = cstat_r[`XPI_EDGE_SEL_BIT] && en_r[`XPI_BIT_LINE_ASYNC] && global_irq_en;
  assign lvl_only = sense_r[1:0] == 2'b00 && en_r[7:5] == 3'b010;
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_IO_CLK: assert property (io_clk_run == !deep)
    else $error("io clock run flag wrong for sleep state");
  AST_IRQ_OR: assert property (irq == (|irq_req))
    else $error("irq differs from OR of requests");
  AST_GIE: assert property (!global_irq_en |-> irq_req == 3'b000)
    else $error("request without global enable");
  AST_LEVEL: assert property ((lvl0_on && !ext_irq_line_zero && awake)[*4] |-> irq_req[0])
    else $error("level request missing while pin low");
  AST_FALL: assert property (((fall0_on && io_clk_run && ext_irq_line_zero)[*3] ##1
    (fall0_on && io_clk_run && !ext_irq_line_zero)) |-> ##[1:4] irq_req[0])
    else $error("falling edge not requested");
  AST_ASYNC: assert property (((asy_on && !ext_irq_line_async)[*3] ##1
    (asy_on && ext_irq_line_async)) |-> ##[1:4] irq_req[2])
    else $error("async rising edge not requested");
  AST_ACK: assert property (($stable(ext_irq_line_zero))[*4] ##0
    (irq_ack[0] && sense_r[1:0] != 2'b00) |=> !irq_req[0])
    else $error("acknowledge did not clear request");
  AST_FLAG_LVL: assert property ((reg_rd && reg_addr == `XPI_OFS_FLAG &&
    sense_r[1:0] == 2'b00 && $past(sense_r[1:0]) == 2'b00 && $past(sense_r[1:0], 2) == 2'b00)
    |=> !reg_rdata[`XPI_BIT_LINE_ZERO])
    else $error("flag set in level mode");
  AST_STOPPED: assert property (((!io_clk_run && sense_r[1] && en_r[6] && global_irq_en)[*6])
    |-> !$rose(irq_req[0]))
    else $error("edge seen with io clock stopped");
  AST_WAKE_ASYNC: assert property ((deep && $rose(irq_req[2])) |-> ##[0:2] wake_req)
    else $error("async edge did not wake");
  AST_WAKE_LVL: assert property (($rose(wake_req) && deep && lvl_only)
    |-> $past(ext_irq_line_zero, WDT_CYC) == 1'b0)
    else $error("level wake before two oscillator samples");
  COV_LVL_WAKE: cover property ($rose(wake_req) && lvl_only);
  COV_ASY_WAKE: cover property (deep && $rose(irq_req[2]));
  COV_ACK: cover property (irq_ack[0] && irq_req[0]);
endmodule

bind xpi_top xpi_top_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_mon (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_irq_line_zero(ext_irq_line_zero), .ext_irq_line_async(ext_irq_line_async),
  .global_irq_en(global_irq_en), .irq_ack(irq_ack), .sleep_en(sleep_en),
  .sleep_mode(sleep_mode), .irq_req(irq_req), .irq(irq), .io_clk_run(io_clk_run),
  .wake_req(wake_req)
);

// ==== bench/xpi_top_tb.sv ====
// Purpose: Self-checking bench for the external pin interrupt block.
// Assumes: Start-up shortened to 20 cycles; pins idle high.
// Notes:   Lines zero and one share one sense loop.
`timescale 1ns/1ps
`include "xpi_regs.svh"
module xpi_top_tb;
  import xpi_pkg::*;
  logic       clk_sys, rst, reg_wr, reg_rd, wdt_osc_clk, global_irq_en;
  logic       sleep_en, irq, io_clk_run, wake_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] lvl, pin, irq_ack, irq_req;
  xpi_sleep_e sleep_mode;
  int         failures, tests_run;
  xpi_top #(.STARTUP_CYCLES(20)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_irq_line_zero(pin[0]), .ext_irq_line_one(pin[1]), .ext_irq_line_async(pin[2]),
    .wdt_osc_clk(wdt_osc_clk), .global_irq_en(global_irq_en), .irq_ack(irq_ack),
    .sleep_en(sleep_en), .sleep_mode(sleep_mode), .irq_req(irq_req), .irq(irq),
    .io_clk_run(io_clk_run), .wake_req(wake_req)
  );
  xpi_pin_src u_src (.lvl(lvl), .pin(pin), .wdt_clk(wdt_osc_clk));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stands one cycle only, so compare right after the second edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask
  task automatic setp(input int l, input logic v);
    @(posedge clk_sys);
    lvl[l] <= v;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    $display("ERROR watchdog expected end seen timeout");
    end_sim();
  end
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    int l, c, n;
    {reg_addr, reg_wdata, reg_wr, reg_rd, irq_ack, sleep_en, global_irq_en} = '0;
    lvl = 3'b111;
    sleep_mode = XPI_SLP_IDLE;
    rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    tick(3);
    for (c = 0; c < 4; c++) rd(8'(c), `XPI_RST_BYTE, "reset_val");
    rd(`XPI_OFS_STATE, 8'h87, "state");
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00, "unmapped");
    wr(`XPI_OFS_ENABLE, 8'hC0);
    rd(`XPI_OFS_ENABLE, 8'hC0, "enable");
    @(posedge clk_sys);
    global_irq_en <= 1'b1;
    for (l = 0; l < 2; l++) for (c = 0; c < 4; c++) begin
      wr(`XPI_OFS_SENSE, 8'(c << (2 * l)));
      wr(`XPI_OFS_FLAG, 8'hE0);
      setp(l, 1'b0);
      tick(4);
      chk("req_fall", 8'(c != 3), {7'h00, irq_req[l]});
      rd(`XPI_OFS_FLAG, {7'h00, c == 1 || c == 2} << (6 + l), "flag_fall");
      wr(`XPI_OFS_FLAG, 8'hE0);
      setp(l, 1'b1);
      tick(4);
      chk("req_rise", 8'(c == 1 || c == 3), {7'h00, irq_req[l]});
      rd(`XPI_OFS_FLAG, {7'h00, c == 1 || c == 3} << (6 + l), "flag_rise");
      wr(`XPI_OFS_FLAG, 8'hE0);
    end
    wr(`XPI_OFS_ENABLE, 8'h20);
    for (c = 0; c < 2; c++) begin
      wr(`XPI_OFS_CSTAT, 8'(c << 6));
      wr(`XPI_OFS_FLAG, 8'hE0);
      setp(2, 1'b0);
      tick(4);
      rd(`XPI_OFS_FLAG, (c == 0) ? 8'h20 : 8'h00, "async_fall");
      wr(`XPI_OFS_FLAG, 8'hE0);
      setp(2, 1'b1);
      tick(4);
      rd(`XPI_OFS_FLAG, (c == 1) ? 8'h20 : 8'h00, "async_rise");
      wr(`XPI_OFS_FLAG, 8'hE0);
    end
    @(posedge clk_sys);
    global_irq_en <= 1'b0;
    wr(`XPI_OFS_ENABLE, 8'h40);
    wr(`XPI_OFS_SENSE, 8'h02);
    setp(0, 1'b0);
    tick(4);
    chk("req_gie_off", 8'h00, {5'h00, irq_req});
    rd(`XPI_OFS_FLAG, 8'h40, "flag_gie_off");
    @(posedge clk_sys);
    global_irq_en <= 1'b1;
    tick(1);
    chk("irq_gie_on", 8'h01, {7'h00, irq});
    @(posedge clk_sys);
    irq_ack <= 3'b001;
    @(posedge clk_sys);
    irq_ack <= 3'b000;
    #1;
    chk("irq_ack", 8'h00, {7'h00, irq});
    setp(0, 1'b1);
    for (c = 0; c < 6; c++) begin
      @(posedge clk_sys);
      sleep_en <= 1'b1;
      sleep_mode <= xpi_sleep_e'(c);
      tick(1);
      chk("io_run", 8'(c == 0), {7'h00, io_clk_run});
    end
    setp(0, 1'b0);
    tick(4);
    rd(`XPI_OFS_FLAG, 8'h00, "edge_stopped");
    // Pin stays low across the restart, so a stale sample would show a false fall
    @(posedge clk_sys);
    sleep_en <= 1'b0;
    tick(4);
    rd(`XPI_OFS_FLAG, 8'h00, "edge_restart");
    setp(0, 1'b1);
    wr(`XPI_OFS_CSTAT, 8'h00);
    wr(`XPI_OFS_FLAG, 8'hE0);
    wr(`XPI_OFS_ENABLE, 8'h20);
    @(posedge clk_sys);
    sleep_en <= 1'b1;
    sleep_mode <= XPI_SLP_PDOWN;
    setp(2, 1'b0);
    tick(5);
    chk("wake_async", 8'h01, {7'h00, wake_req});
    @(posedge clk_sys);
    sleep_en <= 1'b0;
    tick(2);
    chk("wake_clear", 8'h00, {7'h00, wake_req});
    setp(2, 1'b1);
    wr(`XPI_OFS_SENSE, 8'h00);
    wr(`XPI_OFS_ENABLE, 8'h40);
    wr(`XPI_OFS_FLAG, 8'hE0);
    // Second pass drops the level right after wake, before start-up ends
    for (c = 0; c < 2; c++) begin
      @(posedge clk_sys);
      sleep_en <= 1'b1;
      setp(0, 1'b0);
      tick(1);
      n = 0;
      while (wake_req !== 1'b1 && n < 400) begin
        tick(1);
        n++;
      end
      chk("wake_lvl", 8'h01, {7'h00, wake_req});
      chk("wake_late", 8'h01, 8'(n >= 120));
      if (c == 1) setp(0, 1'b1);
      @(posedge clk_sys);
      sleep_en <= 1'b0;
      tick(30);
      chk("lvl_req", 8'(c == 0), {7'h00, irq_req[0]});
      setp(0, 1'b1);
      tick(4);
    end
    end_sim();
  end
endmodule
